// [hw/red_pkg.sv]
//   Purpose: Shared constants and types for the rotary encoder decoder
//   Assumes: Encoder switches or buttons are active high after any board logic
//   Notes:   Switch state is {switch 2, switch 1}; forward rotation walks 00-01-11-10
package red_pkg;

  // ****************************************************************
  // Widths and depths
  // ****************************************************************
  localparam int SW_W         = 2;
  localparam int HIST_DEPTH   = 4;
  localparam int PTR_W        = 2;
  localparam int POS_W        = 16;
  localparam int SEL_W        = 3;
  localparam int BTN_UP_BIT   = 0;
  localparam int BTN_DN_BIT   = 1;

  // ****************************************************************
  // Switch states and decode select codes
  // ****************************************************************
  typedef logic [SW_W-1:0] red_sw_type;

  localparam red_sw_type ST_00 = 2'h0;
  localparam red_sw_type ST_01 = 2'h1;
  localparam red_sw_type ST_11 = 2'h3;
  localparam red_sw_type ST_10 = 2'h2;

  localparam logic [SEL_W-1:0] SEL_TWO_PAIR   = 3'h1;
  localparam logic [SEL_W-1:0] SEL_ONE_PAIR_A = 3'h2;
  localparam logic [SEL_W-1:0] SEL_ONE_PAIR_B = 3'h3;
  localparam logic [SEL_W-1:0] SEL_BUTTONS    = 3'h4;
  localparam logic [SEL_W-1:0] SEL_ALL_PAIRS  = 3'h5;

  // ****************************************************************
  // Counts and reset values
  // ****************************************************************
  localparam logic [PTR_W-1:0] PTR_ONE     = 2'h1;
  localparam logic [PTR_W-1:0] PTR_RESET   = 2'h0;
  localparam logic [1:0]       FILL_ONE    = 2'h1;
  localparam logic [1:0]       FILL_NEEDED = 2'h2;
  localparam logic [1:0]       FILL_RESET  = 2'h0;
  localparam logic [POS_W-1:0] POS_STEP    = 16'h0001;
  localparam logic [POS_W-1:0] POS_RESET   = 16'h0000;

endpackage

// [hw/red_sync.sv]
//   Purpose: Two flip-flop synchroniser for the switch inputs
//   Assumes: Inputs may change at any time with respect to the clock
//   Notes:   Stage one is read only by stage two
module red_sync
  import red_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
    logic [1:0]       age;
  } red_sync_type;

  red_sync_type st_reg;
  red_sync_type st_next;

  // Age only feeds the check below; it saturates after two edges
  always_comb begin
    st_next      = st_reg;
    st_next.meta = d_in;
    st_next.q    = st_reg.meta;
    if (st_reg.age != FILL_NEEDED) begin
      st_next.age = st_reg.age + FILL_ONE;
    end
  end

  // Reset to constants only
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_out = st_reg.q;

  a_sync_two_stage: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (st_reg.age == FILL_NEEDED) |-> (q_out == $past(d_in, 2)))
    else $error("synchroniser output is not the input two cycles late");

endmodule

// [hw/red_decoder.sv]
//   Purpose: Quadrature rotary encoder decoder for menu stepping
//   Assumes: Decode select is static while turning; inputs active high
//   Notes:   Other select codes count nothing but still log changes
module red_decoder
  import red_pkg::*;
(
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             sw1_in,
  input  wire logic             sw2_in,
  input  wire logic [SEL_W-1:0] decode_sel_in,
  output logic                  count_up_out,
  output logic                  count_down_out,
  output logic      [POS_W-1:0] position_out,
  output red_sw_type            sw_state_out,
  output logic                  change_out
);

  // ****************************************************************
  // State and types
  // ****************************************************************
  typedef struct packed {
    logic [HIST_DEPTH-1:0][SW_W-1:0] hist;
    logic [PTR_W-1:0]                wp;
    logic [1:0]                      fill;
    red_sw_type                      cur;
    logic                            evt;
    logic                            up;
    logic                            dn;
    logic [POS_W-1:0]                pos;
  } red_state_type;

  red_state_type st_reg;
  red_state_type st_next;
  red_sw_type    sync_q;
  red_sw_type    old_s0;
  red_sw_type    old_s1;
  logic          fwd_seq;
  logic          rev_seq;
  logic          up_rise;
  logic          dn_rise;

  // ****************************************************************
  // Sequence helpers
  // ****************************************************************
  // Next state in forward direction along the gray cycle
  function automatic red_sw_type fwd_next(input red_sw_type s);
    red_sw_type r;
    case (s)
      ST_00:   r = ST_01;
      ST_01:   r = ST_11;
      ST_11:   r = ST_10;
      default: r = ST_00;
    endcase
    return r;
  endfunction

  // Next state in reverse direction along the gray cycle
  function automatic red_sw_type rev_next(input red_sw_type s);
    red_sw_type r;
    case (s)
      ST_00:   r = ST_10;
      ST_10:   r = ST_11;
      ST_11:   r = ST_01;
      default: r = ST_00;
    endcase
    return r;
  endfunction

  // Which end states of a sequence pair are watched per select code
  function automatic logic end_watched(input logic [SEL_W-1:0] sel,
                                       input red_sw_type       s);
    logic w;
    case (sel)
      SEL_ONE_PAIR_A: w = (s == ST_00);
      SEL_ONE_PAIR_B: w = (s == ST_11);
      SEL_TWO_PAIR:   w = (s == ST_00) || (s == ST_11);
      SEL_ALL_PAIRS:  w = 1'b1;
      default:        w = 1'b0;
    endcase
    return w;
  endfunction

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  red_sync #(
    .WIDTH (SW_W)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .d_in       ({sw2_in, sw1_in}),
    .q_out      (sync_q)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Two oldest states of the window; the new state is the third
  assign old_s0  = st_reg.hist[st_reg.wp - PTR_ONE];
  assign old_s1  = st_reg.hist[st_reg.wp];
  // Reversal inside a window breaks both chains, so bounce never counts
  assign fwd_seq = (old_s1 == fwd_next(old_s0)) && (sync_q == fwd_next(old_s1));
  assign rev_seq = (old_s1 == rev_next(old_s0)) && (sync_q == rev_next(old_s1));
  // Both buttons at once is ambiguous, so neither counts
  assign up_rise = sync_q[BTN_UP_BIT] && !st_reg.cur[BTN_UP_BIT];
  assign dn_rise = sync_q[BTN_DN_BIT] && !st_reg.cur[BTN_DN_BIT];

  // Next state: log, evaluate, count
  always_comb begin
    st_next     = st_reg;
    st_next.evt = 1'b0;
    st_next.up  = 1'b0;
    st_next.dn  = 1'b0;
    if (sync_q != st_reg.cur) begin
      st_next.evt            = 1'b1;
      st_next.cur            = sync_q;
      st_next.wp             = st_reg.wp + PTR_ONE;
      st_next.hist[st_next.wp] = sync_q;
      if (st_reg.fill != FILL_NEEDED) begin
        st_next.fill = st_reg.fill + FILL_ONE;
      end
      if (decode_sel_in == SEL_BUTTONS) begin
        st_next.up = up_rise && !dn_rise;
        st_next.dn = dn_rise && !up_rise;
      end else if ((st_reg.fill == FILL_NEEDED)
                   && end_watched(decode_sel_in, sync_q)) begin
        st_next.up = fwd_seq;
        st_next.dn = rev_seq;
      end
    end
    // Position wraps; menus only look at the steps
    if (st_next.up) begin
      st_next.pos = st_reg.pos + POS_STEP;
    end else if (st_next.dn) begin
      st_next.pos = st_reg.pos - POS_STEP;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg      <= '0;
      st_reg.wp   <= PTR_RESET;
      st_reg.fill <= FILL_RESET;
      st_reg.pos  <= POS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign count_up_out   = st_reg.up;
  assign count_down_out = st_reg.dn;
  assign position_out   = st_reg.pos;
  assign sw_state_out   = st_reg.cur;
  assign change_out     = st_reg.evt;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_step_exclusive: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !(count_up_out && count_down_out))
    else $error("up and down step in the same cycle");

  a_step_needs_change: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (count_up_out || count_down_out) |-> (change_out && sw_state_out != $past(sw_state_out)))
    else $error("step without a logged switch change");

  a_change_logged: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (sync_q != sw_state_out) |=> (change_out && sw_state_out == $past(sync_q)
                                  && st_reg.hist[st_reg.wp] == $past(sync_q)))
    else $error("switch change not logged into history");

  a_one_pair_end: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ((count_up_out || count_down_out) && $past(decode_sel_in) == SEL_ONE_PAIR_A)
      |-> (sw_state_out == ST_00))
    else $error("single pair mode counted at a wrong state");

  a_two_pair_end: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ((count_up_out || count_down_out) && $past(decode_sel_in) == SEL_TWO_PAIR)
      |-> (sw_state_out == ST_00 || sw_state_out == ST_11))
    else $error("two pair mode counted at a wrong state");

  a_full_res_fwd: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (decode_sel_in == SEL_ALL_PAIRS && st_reg.fill == FILL_NEEDED
     && sync_q != st_reg.cur && fwd_seq) |=> count_up_out)
    else $error("full resolution missed a forward step");

  a_bounce_blocked: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (decode_sel_in != SEL_BUTTONS && sync_q != st_reg.cur && sync_q == old_s0)
      |=> !(count_up_out || count_down_out))
    else $error("bounce back produced a step");

  a_button_up: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (decode_sel_in == SEL_BUTTONS && up_rise && !dn_rise) |=> (count_up_out
      && position_out == $past(position_out) + POS_STEP))
    else $error("button press did not step up");

  a_idle_select: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ($past(decode_sel_in) == 3'h0 || $past(decode_sel_in) > SEL_ALL_PAIRS)
      |-> !(count_up_out || count_down_out))
    else $error("step with an unused select code");

endmodule

// [verification/red_enc_model.sv]
// Purpose: Behavioural two-switch rotary encoder facing the decoder
// Assumes: Switches active high; forward rotation walks 00-01-11-10
// Notes:   Each state dwells long enough to clear the synchroniser
module red_enc_model (
  input  wire logic ref_clk_in,
  output logic      sw1_out,
  output logic      sw2_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] pos_idx;

  // ****************************************************************
  // Switch drive
  // ****************************************************************
  // Quiet contacts, encoder parked at a detent; bench calls this at time zero
  task automatic park();
    pos_idx = 2'h0;
    {sw2_out, sw1_out} = 2'h0;
  endtask

  // Set {sw2, sw1} off the sampling edge, then dwell
  task automatic put(input logic [1:0] s);
    @(negedge ref_clk_in);
    {sw2_out, sw1_out} = s;
    repeat (6) @(negedge ref_clk_in);
  endtask

  // One step; gray order so only one switch moves, as a real shaft does
  task automatic turn(input logic fwd);
    logic [1:0] code;
    pos_idx = fwd ? pos_idx + 2'h1 : pos_idx - 2'h1;
    code = {pos_idx[1], pos_idx[1] ^ pos_idx[0]};
    put(code);
  endtask
endmodule

// [verification/tb_red_decoder.sv]
// Purpose: Self-checking bench for the rotary encoder decoder
// Assumes: Encoder model drives the switches; bench drives select and reset
// Notes:   Pulses are tallied on every rising edge and judged as deltas per scenario
module tb_red_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import red_pkg::*;

  logic             ref_clk_in = 1'b0;
  logic             rst_n_in;
  logic [SEL_W-1:0] decode_sel_in;
  logic             sw1;
  logic             sw2;
  logic             count_up_out;
  logic             count_down_out;
  logic             change_out;
  logic [POS_W-1:0] position_out;
  red_sw_type       sw_state_out;
  logic [15:0]      ups = 16'h0000, dns = 16'h0000, chs = 16'h0000;
  logic [15:0]      u0, d0, c0, p0;
  int               n_errors = 0;
  int               total_checks = 0;

  // ****************************************************************
  // Clock, parts and pulse tally
  // ****************************************************************
  always #5 ref_clk_in = ~ref_clk_in;

  red_enc_model ENC (.ref_clk_in(ref_clk_in), .sw1_out(sw1), .sw2_out(sw2));

  red_decoder DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sw1_in(sw1),
    .sw2_in(sw2), .decode_sel_in(decode_sel_in), .count_up_out(count_up_out),
    .count_down_out(count_down_out), .position_out(position_out),
    .sw_state_out(sw_state_out), .change_out(change_out));

  // Counting here lets a scenario see every one-cycle pulse
  always @(posedge ref_clk_in) begin
    if (count_up_out === 1'b1) ups <= ups + 16'h0001;
    if (count_down_out === 1'b1) dns <= dns + 16'h0001;
    if (change_out === 1'b1) chs <= chs + 16'h0001;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic compare_val(input string what, input logic [15:0] exp,
                             input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Select is set off-edge and held static until the next start
  task automatic start(input logic [SEL_W-1:0] sel);
    @(negedge ref_clk_in);
    decode_sel_in = sel;
    {u0, d0, c0, p0} = {ups, dns, chs, position_out};
  endtask

  task automatic expect_delta(input logic [15:0] eu, input logic [15:0] ed,
                              input logic [15:0] ec);
    compare_val("up count", eu, ups - u0);
    compare_val("down count", ed, dns - d0);
    compare_val("change count", ec, chs - c0);
    compare_val("position", eu - ed, position_out - p0);
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, then prime the history with forward steps
  task automatic scen_reset();
    repeat (4) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    compare_val("position", 16'h0000, position_out);
    compare_val("state", 16'h0000, 16'(sw_state_out));
    start(SEL_ALL_PAIRS);
    repeat (4) ENC.turn(1'b1);
  endtask

  // Highest resolution, plus exact input-to-output latency
  task automatic scen_sel5_fwd();
    start(SEL_ALL_PAIRS);
    fork
      ENC.turn(1'b1);
      begin
        @(negedge ref_clk_in);
        // Sampled at the first edge, synchronised at the second, logged at the third
        repeat (2) @(posedge ref_clk_in);
        #1 compare_val("early change", 16'h0000, 16'(change_out));
        @(posedge ref_clk_in);
        #1 compare_val("change", 16'h0001, 16'(change_out));
        compare_val("up pulse", 16'h0001, 16'(count_up_out));
        compare_val("state", 16'h0001, 16'(sw_state_out));
      end
    join
    repeat (3) ENC.turn(1'b1);
    expect_delta(16'h0004, 16'h0000, 16'h0004);
  endtask

  // Two watched pairs count twice per cycle
  task automatic scen_sel1();
    start(SEL_TWO_PAIR);
    repeat (4) ENC.turn(1'b1);
    expect_delta(16'h0002, 16'h0000, 16'h0004);
  endtask

  // One watched pair counts once per cycle, both codes
  task automatic scen_sel23();
    start(SEL_ONE_PAIR_A);
    repeat (4) ENC.turn(1'b1);
    expect_delta(16'h0001, 16'h0000, 16'h0004);
    start(SEL_ONE_PAIR_B);
    repeat (4) ENC.turn(1'b1);
    expect_delta(16'h0001, 16'h0000, 16'h0004);
  endtask

  // Unused select logs changes but never counts
  task automatic scen_sel0();
    start(3'h0);
    repeat (4) ENC.turn(1'b1);
    expect_delta(16'h0000, 16'h0000, 16'h0004);
  endtask

  // Reversal: first step mixes directions and is dropped
  task automatic scen_rev();
    start(SEL_ALL_PAIRS);
    repeat (8) ENC.turn(1'b0);
    expect_delta(16'h0000, 16'h0007, 16'h0008);
  endtask

  // Chatter at a detent must not toggle up and down
  task automatic scen_bounce();
    start(SEL_ALL_PAIRS);
    repeat (2) begin
      ENC.put(ST_01);
      ENC.put(ST_00);
    end
    expect_delta(16'h0000, 16'h0000, 16'h0004);
    compare_val("state", 16'h0000, 16'(sw_state_out));
  endtask

  // Separate up and down buttons
  task automatic scen_buttons();
    start(SEL_BUTTONS);
    ENC.put(ST_01);
    ENC.put(ST_00);
    ENC.put(ST_10);
    ENC.put(ST_00);
    // Both buttons at once is ambiguous: logged, never counted
    ENC.put(ST_11);
    ENC.put(ST_00);
    expect_delta(16'h0001, 16'h0001, 16'h0006);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    rst_n_in      = 1'b0;
    decode_sel_in = SEL_ALL_PAIRS;
    ENC.park();
    scen_reset();
    scen_sel5_fwd();
    scen_sel1();
    scen_sel23();
    scen_sel0();
    scen_rev();
    scen_bounce();
    scen_buttons();
    end_of_test();
  end

  // Run needs about 3 us; a hang is cut off well beyond that
  initial begin
    #40us;
    n_errors++;
    end_of_test();
  end
endmodule
